// ==== actsel_pkg.sv ====
// Package: constants and types for the ADC channel trigger selection bank
//--------------------------------------------------------------
// Contract
// - Six low registers, selectors 4x+1 and 4x
// - Six high registers, selectors 4x+3 and 4x+2
// - Bits 15-13 and 7-5 read zero
// - Code zero gives no trigger
// - Code 1 routes common software trigger
// - Code 2 routes level software trigger
// - Code 4 routes PWM special event trigger
// - Codes 5-10 route PWM primary triggers 1-6
// - Codes 12, 13 route timer period matches
// - Code 14 routes PWM secondary special event
// - Codes 15-20 route PWM secondary triggers 1-6
// - Codes 22, 23 route output compares
// - Codes 24-29 route PWM current limits 1-6
// - Code 30 routes trigger generator output
// - Code 31 routes external trigger input
// - Level enable picks level or edge sensitivity
//--------------------------------------------------------------
package actsel_pkg;

    localparam int          NUM_CH    = 24;
    localparam int          NUM_PAIR  = 6;
    localparam int          ADDR_W    = 4;
    localparam int          DATA_W    = 16;
    localparam int          SEL_W     = 5;
    localparam int          NUM_CODE  = 32;

    // Register indices on the plain register port
    localparam logic [3:0]  OFF_LOW0  = 4'h0;
    localparam logic [3:0]  OFF_HIGH0 = 4'h6;
    localparam logic [3:0]  OFF_LVL_L = 4'hC;
    localparam logic [3:0]  OFF_LVL_H = 4'hD;

    // Field positions inside a selection register
    localparam int          FLD_EVEN  = 0;
    localparam int          FLD_ODD   = 8;
    localparam logic [15:0] SEL_MASK  = 16'h1F1F;
    localparam int          LVL_HI_CH = 16;

    // Values after reset
    localparam logic [4:0]  SEL_RST   = 5'h00;
    localparam logic [23:0] LVL_RST   = 24'h000000;

    // Selector codes
    localparam logic [4:0]  CODE_NONE     = 5'h00;
    localparam logic [4:0]  CODE_SW_COM   = 5'h01;
    localparam logic [4:0]  CODE_SW_LVL   = 5'h02;
    localparam logic [4:0]  CODE_RSVD     = 5'h03;
    localparam logic [4:0]  CODE_PWM_SE   = 5'h04;
    localparam logic [4:0]  CODE_PWM_PRI1 = 5'h05;
    localparam logic [4:0]  CODE_CELL1    = 5'h0B;
    localparam logic [4:0]  CODE_TMR1     = 5'h0C;
    localparam logic [4:0]  CODE_TMR2     = 5'h0D;
    localparam logic [4:0]  CODE_PWM_SSE  = 5'h0E;
    localparam logic [4:0]  CODE_PWM_SEC1 = 5'h0F;
    localparam logic [4:0]  CODE_CELL2    = 5'h15;
    localparam logic [4:0]  CODE_OC1      = 5'h16;
    localparam logic [4:0]  CODE_OC2      = 5'h17;
    localparam logic [4:0]  CODE_PWM_CL1  = 5'h18;
    localparam logic [4:0]  CODE_TRG_GEN  = 5'h1E;
    localparam logic [4:0]  CODE_EXT      = 5'h1F;
    localparam int          NUM_PWM_GEN   = 6;

    typedef logic [4:0] actsel_sel_t;

    // Event sources, each high while or when its event occurs
    typedef struct packed {
        logic       extTrig;
        logic       trigGenOut;
        logic [5:0] pwmCurLim;
        logic       ocTwo;
        logic       ocOne;
        logic       logicCellTwo;
        logic [5:0] pwmSecTrig;
        logic       pwmSecSpecial;
        logic       timer2Period;
        logic       timer1Period;
        logic       logicCellOne;
        logic [5:0] pwmPrimTrig;
        logic       pwmSpecial;
        logic       swLevel;
        logic       swCommon;
    } actsel_src_t;

endpackage : actsel_pkg

// ==== actsel_trigger_select.sv ====
// Module: per-channel conversion trigger selection with register port
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module actsel_trigger_select (
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    input  wire logic [3:0]           regAddr,
    input  wire logic [15:0]          regWrData,
    input  wire logic                 regWrEn,
    input  wire logic                 regRdEn,
    output logic      [15:0]          regRdData,
    input  wire actsel_pkg::actsel_src_t trigSrc,
    output logic      [23:0]          convReq
);

    //----------------------------------------------------------
    // Selection helpers
    //----------------------------------------------------------
    function automatic logic pickSource(
        input logic [31:0] vec,
        input logic [4:0]  sel
    );
        logic res;
        res = vec[sel];
        if (sel == actsel_pkg::CODE_NONE) begin
            res = 1'b0;
        end
        if (sel == actsel_pkg::CODE_RSVD) begin
            res = 1'b0;
        end
        return res;
    endfunction : pickSource

    function automatic logic [3:0] chanAddr(input int ch);
        logic [3:0] base;
        base = ((ch % 4) < 2) ? actsel_pkg::OFF_LOW0 : actsel_pkg::OFF_HIGH0;
        return base + 4'(ch / 4);
    endfunction : chanAddr

    //----------------------------------------------------------
    // State
    //----------------------------------------------------------
    actsel_pkg::actsel_sel_t selQ [24];
    actsel_pkg::actsel_sel_t selD [24];
    logic [23:0]             lvlQ;
    logic [23:0]             lvlD;
    logic [31:0]             srcVec;
    logic [31:0]             prevSrc_q;
    logic [23:0]             convReq_d;
    logic [23:0]             convReq_q;
    logic [15:0]             rdData_d;
    logic [15:0]             rdData_q;

    //----------------------------------------------------------
    // Source vector by selector code
    //----------------------------------------------------------
    always_comb begin
        srcVec = 32'h0000_0000;
        srcVec[actsel_pkg::CODE_SW_COM]  = trigSrc.swCommon;
        srcVec[actsel_pkg::CODE_SW_LVL]  = trigSrc.swLevel;
        srcVec[actsel_pkg::CODE_PWM_SE]  = trigSrc.pwmSpecial;
        srcVec[actsel_pkg::CODE_CELL1]   = trigSrc.logicCellOne;
        srcVec[actsel_pkg::CODE_CELL2]   = trigSrc.logicCellTwo;
        srcVec[actsel_pkg::CODE_TMR1]    = trigSrc.timer1Period;
        srcVec[actsel_pkg::CODE_TMR2]    = trigSrc.timer2Period;
        srcVec[actsel_pkg::CODE_PWM_SSE] = trigSrc.pwmSecSpecial;
        srcVec[actsel_pkg::CODE_OC1]     = trigSrc.ocOne;
        srcVec[actsel_pkg::CODE_OC2]     = trigSrc.ocTwo;
        srcVec[actsel_pkg::CODE_TRG_GEN] = trigSrc.trigGenOut;
        srcVec[actsel_pkg::CODE_EXT]     = trigSrc.extTrig;
        for (int k = 0; k < actsel_pkg::NUM_PWM_GEN; k++) begin
            srcVec[actsel_pkg::CODE_PWM_PRI1 + k] = trigSrc.pwmPrimTrig[k];
            srcVec[actsel_pkg::CODE_PWM_SEC1 + k] = trigSrc.pwmSecTrig[k];
            srcVec[actsel_pkg::CODE_PWM_CL1 + k]  = trigSrc.pwmCurLim[k];
        end
    end

    //----------------------------------------------------------
    // Register writes
    //----------------------------------------------------------
    always_comb begin
        lvlD = lvlQ;
        for (int c = 0; c < actsel_pkg::NUM_CH; c++) begin
            selD[c] = selQ[c];
            if (regWrEn && regAddr == chanAddr(c)) begin
                if ((c % 2) == 1) begin
                    selD[c] = regWrData[actsel_pkg::FLD_ODD +: actsel_pkg::SEL_W];
                end else begin
                    selD[c] = regWrData[actsel_pkg::FLD_EVEN +: actsel_pkg::SEL_W];
                end
            end
        end
        if (regWrEn && regAddr == actsel_pkg::OFF_LVL_L) begin
            lvlD[15:0] = regWrData;
        end
        if (regWrEn && regAddr == actsel_pkg::OFF_LVL_H) begin
            lvlD[23:16] = regWrData[7:0];
        end
    end

    //----------------------------------------------------------
    // Register reads, answered one cycle later
    //----------------------------------------------------------
    always_comb begin
        rdData_d = 16'h0000;
        if (regRdEn) begin
            for (int c = 0; c < actsel_pkg::NUM_CH; c++) begin
                if (regAddr == chanAddr(c)) begin
                    // Unimplemented bits stay zero by construction
                    if ((c % 2) == 1) begin
                        rdData_d[actsel_pkg::FLD_ODD +: actsel_pkg::SEL_W] = selQ[c];
                    end else begin
                        rdData_d[actsel_pkg::FLD_EVEN +: actsel_pkg::SEL_W] = selQ[c];
                    end
                end
            end
            if (regAddr == actsel_pkg::OFF_LVL_L) begin
                rdData_d = lvlQ[15:0];
            end
            if (regAddr == actsel_pkg::OFF_LVL_H) begin
                rdData_d = {8'h00, lvlQ[23:16]};
            end
        end
    end

    //----------------------------------------------------------
    // Conversion request per channel
    //----------------------------------------------------------
    always_comb begin
        for (int c = 0; c < actsel_pkg::NUM_CH; c++) begin
            if (lvlQ[c]) begin
                convReq_d[c] = pickSource(srcVec, selQ[c]);
            end else begin
                // Edge mode: one request per rising edge of the source
                convReq_d[c] = pickSource(srcVec & ~prevSrc_q, selQ[c]);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < actsel_pkg::NUM_CH; c++) begin
                selQ[c] <= actsel_pkg::SEL_RST;
            end
            lvlQ      <= actsel_pkg::LVL_RST;
            prevSrc_q <= 32'h0000_0000;
            convReq_q <= 24'h000000;
            rdData_q  <= 16'h0000;
        end else begin
            for (int c = 0; c < actsel_pkg::NUM_CH; c++) begin
                selQ[c] <= selD[c];
            end
            lvlQ      <= lvlD;
            prevSrc_q <= srcVec;
            convReq_q <= convReq_d;
            rdData_q  <= rdData_d;
        end
    end

    assign convReq   = convReq_q;
    assign regRdData = rdData_q;

    //----------------------------------------------------------
    // Checks
    //----------------------------------------------------------
    property p_rsvdZero;
        @(posedge core_clk) disable iff (!arst_n)
        $past(regRdEn) && $past(regAddr) < actsel_pkg::OFF_LVL_L
            |-> (regRdData & ~actsel_pkg::SEL_MASK) == 16'h0000;
    endproperty
    a_rsvdZero: assert property (p_rsvdZero) else $error("reserved bits nonzero");

    property p_readLow;
        @(posedge core_clk) disable iff (!arst_n)
        (regWrEn && regAddr == actsel_pkg::OFF_LOW0) ##1
        (regRdEn && regAddr == actsel_pkg::OFF_LOW0)
            |=> regRdData == ($past(regWrData, 2) & actsel_pkg::SEL_MASK);
    endproperty
    a_readLow: assert property (p_readLow) else $error("low readback wrong");

    property p_readHigh;
        @(posedge core_clk) disable iff (!arst_n)
        (regWrEn && regAddr == actsel_pkg::OFF_HIGH0) ##1
        (regRdEn && regAddr == actsel_pkg::OFF_HIGH0)
            |=> regRdData == ($past(regWrData, 2) & actsel_pkg::SEL_MASK);
    endproperty
    a_readHigh: assert property (p_readHigh) else $error("high readback wrong");

    property p_rdOnlyOnce;
        @(posedge core_clk) disable iff (!arst_n)
        !regRdEn |=> regRdData == 16'h0000;
    endproperty
    a_rdOnlyOnce: assert property (p_rdOnlyOnce) else $error("read data stood too long");

    property p_extLevel;
        @(posedge core_clk) disable iff (!arst_n)
        (selQ[0] == actsel_pkg::CODE_EXT && lvlQ[0] && trigSrc.extTrig)
            |=> convReq[0];
    endproperty
    a_extLevel: assert property (p_extLevel) else $error("external trigger missed");

    property p_genLevel;
        @(posedge core_clk) disable iff (!arst_n)
        (selQ[1] == actsel_pkg::CODE_TRG_GEN && lvlQ[1] && trigSrc.trigGenOut)
            |=> convReq[1];
    endproperty
    a_genLevel: assert property (p_genLevel) else $error("generator trigger missed");

    for (genvar i = 0; i < actsel_pkg::NUM_CH; i++) begin : g_chk
        property p_noneIdle;
            @(posedge core_clk) disable iff (!arst_n)
            selQ[i] == actsel_pkg::CODE_NONE |=> !convReq[i];
        endproperty
        a_noneIdle: assert property (p_noneIdle) else $error("request with no source");

        property p_levelReq;
            @(posedge core_clk) disable iff (!arst_n)
            lvlQ[i] && selQ[i] != actsel_pkg::CODE_NONE &&
            selQ[i] != actsel_pkg::CODE_RSVD && srcVec[selQ[i]]
                |=> convReq[i];
        endproperty
        a_levelReq: assert property (p_levelReq) else $error("level request missed");

        property p_edgeOnce;
            @(posedge core_clk) disable iff (!arst_n)
            !lvlQ[i] && srcVec[selQ[i]] && prevSrc_q[selQ[i]] |=> !convReq[i];
        endproperty
        a_edgeOnce: assert property (p_edgeOnce) else $error("edge mode repeated");

        property p_edgeReq;
            @(posedge core_clk) disable iff (!arst_n)
            !lvlQ[i] && srcVec[selQ[i]] && !prevSrc_q[selQ[i]] |=> convReq[i];
        endproperty
        a_edgeReq: assert property (p_edgeReq) else $error("edge request missed");

        property p_writeSel;
            @(posedge core_clk) disable iff (!arst_n)
            regWrEn && regAddr == chanAddr(i)
                |=> selQ[i] == $past(regWrData[((i % 2) == 1 ? actsel_pkg::FLD_ODD
                                                : actsel_pkg::FLD_EVEN) +: actsel_pkg::SEL_W]);
        endproperty
        a_writeSel: assert property (p_writeSel) else $error("selector write lost");
    end

    // Source field checks go straight from the input struct, not via srcVec
    property p_swCommon;
        @(posedge core_clk) disable iff (!arst_n)
        (selQ[2] == actsel_pkg::CODE_SW_COM && lvlQ[2] && trigSrc.swCommon)
            |=> convReq[2];
    endproperty
    a_swCommon: assert property (p_swCommon) else $error("software trigger missed");

    property p_swLevel;
        @(posedge core_clk) disable iff (!arst_n)
        (selQ[3] == actsel_pkg::CODE_SW_LVL && lvlQ[3] && trigSrc.swLevel)
            |=> convReq[3];
    endproperty
    a_swLevel: assert property (p_swLevel) else $error("level software trigger missed");

    property p_pwmSpecial;
        @(posedge core_clk) disable iff (!arst_n)
        (selQ[4] == actsel_pkg::CODE_PWM_SE && lvlQ[4] && trigSrc.pwmSpecial)
            |=> convReq[4];
    endproperty
    a_pwmSpecial: assert property (p_pwmSpecial) else $error("special event missed");

    for (genvar k = 0; k < actsel_pkg::NUM_PWM_GEN; k++) begin : g_pwm
        property p_pwmPri;
            @(posedge core_clk) disable iff (!arst_n)
            (selQ[6] == actsel_pkg::CODE_PWM_PRI1 + 5'(k) && lvlQ[6] &&
             trigSrc.pwmPrimTrig[k])
                |=> convReq[6];
        endproperty
        a_pwmPri: assert property (p_pwmPri) else $error("primary trigger missed");

        property p_pwmSec;
            @(posedge core_clk) disable iff (!arst_n)
            (selQ[6] == actsel_pkg::CODE_PWM_SEC1 + 5'(k) && lvlQ[6] &&
             trigSrc.pwmSecTrig[k])
                |=> convReq[6];
        endproperty
        a_pwmSec: assert property (p_pwmSec) else $error("secondary trigger missed");

        property p_pwmLim;
            @(posedge core_clk) disable iff (!arst_n)
            (selQ[6] == actsel_pkg::CODE_PWM_CL1 + 5'(k) && lvlQ[6] &&
             trigSrc.pwmCurLim[k])
                |=> convReq[6];
        endproperty
        a_pwmLim: assert property (p_pwmLim) else $error("current limit trigger missed");
    end

    property p_cells;
        @(posedge core_clk) disable iff (!arst_n)
        lvlQ[7] && ((selQ[7] == actsel_pkg::CODE_CELL1 && trigSrc.logicCellOne) ||
                    (selQ[7] == actsel_pkg::CODE_CELL2 && trigSrc.logicCellTwo))
            |=> convReq[7];
    endproperty
    a_cells: assert property (p_cells) else $error("logic cell trigger missed");

    property p_timers;
        @(posedge core_clk) disable iff (!arst_n)
        lvlQ[8] && ((selQ[8] == actsel_pkg::CODE_TMR1 && trigSrc.timer1Period) ||
                    (selQ[8] == actsel_pkg::CODE_TMR2 && trigSrc.timer2Period))
            |=> convReq[8];
    endproperty
    a_timers: assert property (p_timers) else $error("timer trigger missed");

    property p_pwmSse;
        @(posedge core_clk) disable iff (!arst_n)
        (selQ[9] == actsel_pkg::CODE_PWM_SSE && lvlQ[9] && trigSrc.pwmSecSpecial)
            |=> convReq[9];
    endproperty
    a_pwmSse: assert property (p_pwmSse) else $error("secondary special event missed");

    property p_compares;
        @(posedge core_clk) disable iff (!arst_n)
        lvlQ[10] && ((selQ[10] == actsel_pkg::CODE_OC1 && trigSrc.ocOne) ||
                     (selQ[10] == actsel_pkg::CODE_OC2 && trigSrc.ocTwo))
            |=> convReq[10];
    endproperty
    a_compares: assert property (p_compares) else $error("compare trigger missed");

    c_levelCh0: cover property (@(posedge core_clk) disable iff (!arst_n)
        lvlQ[0] && convReq[0]);
    c_edgeCh5: cover property (@(posedge core_clk) disable iff (!arst_n)
        !lvlQ[5] && convReq[5] ##1 !convReq[5]);
    c_extCh23: cover property (@(posedge core_clk) disable iff (!arst_n)
        selQ[23] == actsel_pkg::CODE_EXT && convReq[23]);
    c_readBack: cover property (@(posedge core_clk) disable iff (!arst_n)
        $past(regRdEn) && regRdData != 16'h0000);

endmodule : actsel_trigger_select

// ==== actsel_src_model.sv ====
// Partner model: registered event sources that feed the trigger selector
`timescale 1ns/1ps
module actsel_src_model (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic [29:0]       nextSrc,
    output actsel_pkg::actsel_src_t trigSrc
);
    // Peripherals launch events from their own flops, so no glitches
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            trigSrc <= '0;
        end else begin
            trigSrc <= actsel_pkg::actsel_src_t'(nextSrc);
        end
    end
endmodule : actsel_src_model

// ==== testbench.sv ====
// Testbench: register bank and trigger routing checks
`timescale 1ns/1ps
module testbench;
    logic                    core_clk;
    logic                    arst_n;
    logic [3:0]              regAddr;
    logic [15:0]             regWrData;
    logic                    regWrEn;
    logic                    regRdEn;
    logic [15:0]             regRdData;
    logic [29:0]             nextSrc;
    actsel_pkg::actsel_src_t trigSrc;
    logic [23:0]             convReq;
    logic [29:0]             sCur;
    logic [29:0]             sPrev;
    logic [4:0]              selQ [24];
    logic [23:0]             lvlQ;
    logic                    chkEn;
    logic [31:0]             seed;
    int                      nFail;
    int                      numChecks;

    actsel_trigger_select u_dut (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .trigSrc(trigSrc), .convReq(convReq));
    actsel_src_model u_src (.core_clk(core_clk), .arst_n(arst_n), .nextSrc(nextSrc),
        .trigSrc(trigSrc));

    always #5 core_clk = ~core_clk;

    // ----------------------------------------
    // Expectations
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic logic [31:0] srcVec(input logic [29:0] s);
        return {s[29:2], 1'b0, s[1:0], 1'b0};
    endfunction : srcVec

    function automatic logic [23:0] expReq();
        logic [23:0] e;
        logic [31:0] v;
        logic [31:0] p;
        v = srcVec(sCur);
        p = srcVec(sPrev);
        for (int c = 0; c < 24; c++) begin
            e[c] = v[selQ[c]] & (lvlQ[c] | ~p[selQ[c]]);
        end
        return e;
    endfunction : expReq

    function automatic logic [15:0] expRd(input logic [3:0] a);
        int k;
        k = (a % 6) * 4 + (a >= 6 ? 2 : 0);
        if (a < 12) return {3'h0, selQ[k + 1], 3'h0, selQ[k]};
        if (a == 12) return lvlQ[15:0];
        if (a == 13) return {8'h00, lvlQ[23:16]};
        return 16'h0000;
    endfunction : expRd

    // Software never programs the reserved code
    function automatic logic [15:0] noRsvd(input logic [15:0] d);
        if (d[4:0] == actsel_pkg::CODE_RSVD) d[4:0] = actsel_pkg::CODE_NONE;
        if (d[12:8] == actsel_pkg::CODE_RSVD) d[12:8] = actsel_pkg::CODE_NONE;
        return d;
    endfunction : noRsvd

    // ----------------------------------------
    // Checks and bus tasks
    // ----------------------------------------
    task automatic checkReg(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : checkReg

    task automatic checkReq(input logic [23:0] got, input logic [23:0] exp);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : checkReq

    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        int k;
        k = (a % 6) * 4 + (a >= 6 ? 2 : 0);
        @(posedge core_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        if (a < 12) begin
            selQ[k]     = d[4:0];
            selQ[k + 1] = d[12:8];
        end
        if (a == 12) lvlQ[15:0] = d;
        if (a == 13) lvlQ[23:16] = d[7:0];
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [3:0] a);
        @(posedge core_clk);
        regReadNow(a);
    endtask : regRead

    // Read strobe raised in the current cycle, so it may follow a write directly
    task automatic regReadNow(input logic [3:0] a);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        checkReg(regRdData, expRd(a));
        @(posedge core_clk);
        #1;
        checkReg(regRdData, 16'h0000);
    endtask : regReadNow

    task automatic readAll();
        for (int a = 0; a < 16; a++) regRead(4'(a));
    endtask : readAll

    // Write strobe followed by read strobe with no gap
    task automatic regWrRd(input logic [3:0] a, input logic [15:0] d);
        regWrite(a, d);
        regReadNow(a);
    endtask : regWrRd

    // Checks start one edge after the last write lands
    task automatic runSrc(input int n);
        @(posedge core_clk);
        chkEn <= 1'b1;
        repeat (n) begin
            @(posedge core_clk);
            seed = xs(seed);
            nextSrc <= seed[29:0];
        end
        @(posedge core_clk);
        chkEn <= 1'b0;
    endtask : runSrc

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sCur  <= '0;
            sPrev <= '0;
        end else begin
            sCur  <= trigSrc;
            sPrev <= sCur;
        end
    end

    always @(negedge core_clk) begin
        if (chkEn) checkReq(convReq, expReq());
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        nFail++;
        wrap_up();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        regAddr = 4'h0;
        regWrData = 16'h0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        nextSrc = '0;
        chkEn = 1'b0;
        seed = 32'h51C95EBA;
        nFail = 0;
        numChecks = 0;
        lvlQ = '0;
        foreach (selQ[i]) selQ[i] = '0;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        readAll();
        for (int a = 0; a < 16; a++) begin
            seed = xs(seed);
            regWrite(4'(a), noRsvd(seed[15:0]));
        end
        readAll();
        for (int a = 0; a < 16; a++) begin
            seed = xs(seed);
            regWrRd(4'(a), noRsvd(seed[15:0]));
        end
        // Every code except reserved code 3 on every channel, in edge mode and then level mode
        for (int c = 0; c < 32; c++) begin
            if (c != 3) begin
                for (int a = 0; a < 12; a++) regWrite(4'(a), {3'h0, 5'(c), 3'h0, 5'(c)});
                for (int m = 0; m < 2; m++) begin
                    regWrite(4'hC, {16{m[0]}});
                    regWrite(4'hD, {16{m[0]}});
                    runSrc(8);
                end
            end
        end
        for (int a = 0; a < 14; a++) begin
            seed = xs(seed);
            regWrite(4'(a), noRsvd(seed[15:0]));
        end
        runSrc(200);
        @(posedge core_clk);
        arst_n <= 1'b0;
        lvlQ = '0;
        foreach (selQ[i]) selQ[i] = '0;
        repeat (3) @(posedge core_clk);
        #1;
        checkReq(convReq, 24'h000000);
        @(posedge core_clk);
        arst_n <= 1'b1;
        readAll();
        wrap_up();
    end
endmodule : testbench
